// *** rtl/arm_defs.vh ***
`ifndef ARM_DEFS_VH
`define ARM_DEFS_VH
// ==========================================
// Map geometry
`define ARM_AW            5
`define ARM_DW            24
`define ARM_OW            32
`define ARM_FIFO_DEPTH    8
`define ARM_FIFO_AW       3
// ==========================================
// Register addresses
`define ARM_A_RESULT      5'h00
`define ARM_A_MOD         5'h08
`define ARM_A_GAIN        5'h0B
`define ARM_A_STATCOM     5'h0C
`define ARM_A_CFGA        5'h0D
`define ARM_A_CFGB        5'h0E
`define ARM_A_OFFC        5'h0F
`define ARM_A_GAINC       5'h10
`define ARM_A_LOCK        5'h1F
`define ARM_A_LAST        5'h1F
// ==========================================
// Loop ranges
`define ARM_G1_LO         5'h08
`define ARM_G1_HI         5'h0C
`define ARM_G2_HI         5'h0E
`define ARM_G3_HI         5'h10
// ==========================================
// Reset values
`define ARM_ZERO          24'h000000
`define ARM_MOD_RST       4'h3
`define ARM_STAT_RST      24'h000000
// ==========================================
// Status and comm fields
`define ARM_RDLOOP_HI     23
`define ARM_RDLOOP_LO     22
`define ARM_WRLOOP_B      21
`define ARM_WCRC_B        20
`define ARM_WDATA_HI      19
`define ARM_WDATA_LO      18
// Configuration_b fields
`define ARM_OFFEN_B       1
`define ARM_GAINEN_B      0
// Security register fields
`define ARM_PW_HI         23
`define ARM_PW_LO         16
// ==========================================
// Codes
`define ARM_LOOP_STATIC   2'h0
`define ARM_LOOP_GROUP    2'h1
`define ARM_LOOP_TYPE     2'h2
`define ARM_LOOP_MAP      2'h3
`define ARM_FMT_16        2'h0
`define ARM_FMT_24        2'h1
`define ARM_FMT_32Z       2'h2
`define ARM_FMT_32S       2'h3
`define ARM_BYTES_2       3'h2
`define ARM_BYTES_3       3'h3
`define ARM_BYTES_4       3'h4
`define ARM_GAIN_SHIFT    23
`define ARM_COMP_W        4
`endif

// *** rtl/arm_core.v ***
`timescale 1ns/10ps
`include "arm_defs.vh"

// ==========================================
// Sample FIFO
module arm_fifo #(
  parameter W  = 24,
  parameter D  = 8,
  parameter AW = 3
) (
  input  wire          mclk_i,
  input  wire          rst_n_i,
  input  wire          ce_i,
  input  wire [W-1:0]  in_data_i,
  input  wire          in_valid_i,
  output reg           in_ready_o,
  output wire [W-1:0]  out_data_o,
  output reg           out_valid_o,
  input  wire          out_ready_i
);
  reg [W-1:0]  mem [0:D-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0]   cnt_q;
  wire         push;
  wire         pop;
  reg  [AW:0]  cnt_d;

  assign push       = in_valid_i & in_ready_o;
  assign pop        = out_valid_o & out_ready_i;
  assign out_data_o = mem[rp_q];
  always @* begin
    cnt_d = cnt_q;
    if (push & ~pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop & ~push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end
  always @(posedge mclk_i) begin
    if (ce_i & push) begin
      mem[wp_q] <= in_data_i;
    end
  end
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_q        <= {AW{1'b0}};
      rp_q        <= {AW{1'b0}};
      cnt_q       <= {(AW+1){1'b0}};
      in_ready_o  <= 1'b0;
      out_valid_o <= 1'b0;
    end else if (ce_i) begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q       <= cnt_d;
      // Registered flags: full blocks source, empty blocks sink
      in_ready_o  <= (cnt_d != D[AW:0]);
      out_valid_o <= (cnt_d != {(AW+1){1'b0}});
    end
  end
endmodule // arm_fifo

// ==========================================
// Register bank
module arm_core (
  input  wire                   mclk_i,
  input  wire                   rst_n_i,
  input  wire                   ce_i,
  input  wire [`ARM_AW-1:0]     acc_addr_i,
  input  wire                   acc_start_i,
  input  wire                   acc_end_i,
  input  wire                   acc_rd_i,
  input  wire                   acc_wr_i,
  input  wire [`ARM_DW-1:0]     acc_wdata_i,
  output reg  [`ARM_OW-1:0]     rd_data_o,
  output reg  [2:0]             rd_bytes_o,
  output reg                    rd_valid_o,
  output reg  [`ARM_AW-1:0]     ptr_o,
  input  wire [`ARM_DW-1:0]     adc_data_i,
  input  wire                   adc_valid_i,
  output wire                   adc_ready_o,
  input  wire                   data_ready_clock_i,
  input  wire                   modulator_clock_i,
  input  wire [`ARM_COMP_W-1:0] comparator_bit_i,
  input  wire [15:0]            map_crc_i,
  output reg                    offset_corr_enable_o,
  output reg                    gain_corr_enable_o
);
  // ==========================================
  // Storage
  reg  [`ARM_DW-1:0]     conversion_result_q;
  reg  [`ARM_DW-1:0]     read_latch_q;
  reg  [`ARM_COMP_W-1:0] modulator_output_q;
  reg  [`ARM_DW-1:0]     pga_gain_config_q;
  reg  [`ARM_DW-1:0]     status_and_comm_q;
  reg  [`ARM_DW-1:0]     configuration_a_q;
  reg  [`ARM_DW-1:0]     configuration_b_q;
  reg  [`ARM_DW-1:0]     offset_correction_q;
  reg  [`ARM_DW-1:0]     gain_correction_q;
  reg  [7:0]             lock_key_q;
  reg  [`ARM_AW-1:0]     ptr_q;
  reg  [`ARM_AW-1:0]     ptr_d;
  reg                    active_q;
  reg                    latched_q;
  wire [`ARM_DW-1:0]     fifo_data;
  wire                   fifo_valid;
  wire                   dr_take;
  wire [1:0]             rd_loop;
  wire                   wr_loop;
  wire [1:0]             wfmt;
  wire [`ARM_AW-1:0]     cur;

  assign rd_loop = status_and_comm_q[`ARM_RDLOOP_HI:`ARM_RDLOOP_LO];
  assign wr_loop = status_and_comm_q[`ARM_WRLOOP_B];
  assign wfmt    = status_and_comm_q[`ARM_WDATA_HI:`ARM_WDATA_LO];
  assign cur     = acc_start_i ? acc_addr_i : ptr_q;
  // ==========================================
  // Sample path; drains only on a data-ready tick so the FIFO backs up
  assign dr_take = data_ready_clock_i & fifo_valid;
  arm_fifo #(
    .W  (`ARM_DW),
    .D  (`ARM_FIFO_DEPTH),
    .AW (`ARM_FIFO_AW)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .ce_i        (ce_i),
    .in_data_i   (adc_data_i),
    .in_valid_i  (adc_valid_i),
    .in_ready_o  (adc_ready_o),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (data_ready_clock_i)
  );

  // ==========================================
  // Calibration
  reg signed [24:0] off_sum;
  reg signed [47:0] gprod;
  reg signed [24:0] g_sum;
  reg        [23:0] cal_val;
  reg        [23:0] stage1;
  always @* begin
    off_sum = $signed({fifo_data[23], fifo_data}) - $signed({offset_correction_q[23],
              offset_correction_q});
    stage1  = fifo_data;
    if (offset_corr_enable_o) begin
      if (off_sum[24] != off_sum[23]) begin
        stage1 = off_sum[24] ? 24'h800000 : 24'h7FFFFF;
      end else begin
        stage1 = off_sum[23:0];
      end
    end
    gprod   = $signed(stage1) * $signed(gain_correction_q);
    g_sum   = $signed({stage1[23], stage1}) + $signed(gprod[47:`ARM_GAIN_SHIFT]);
    cal_val = stage1;
    if (gain_corr_enable_o) begin
      if (g_sum[24] != g_sum[23]) begin
        cal_val = g_sum[24] ? 24'h800000 : 24'h7FFFFF;
      end else begin
        cal_val = g_sum[23:0];
      end
    end
  end

  // ==========================================
  // Address pointer looping
  function [`ARM_AW-1:0] arm_wrap;
    input [`ARM_AW-1:0] p;
    input [`ARM_AW-1:0] lo;
    input [`ARM_AW-1:0] hi;
    begin
      arm_wrap = (p >= hi || p < lo) ? lo : p + 1'b1;
    end
  endfunction
  reg [`ARM_AW-1:0] g_lo;
  reg [`ARM_AW-1:0] g_hi;
  always @* begin
    // Group of the current address
    if (cur == `ARM_A_RESULT) begin
      g_lo = `ARM_A_RESULT;
      g_hi = `ARM_A_RESULT;
    end else if (cur <= `ARM_G1_HI) begin
      g_lo = `ARM_G1_LO;
      g_hi = `ARM_G1_HI;
    end else if (cur <= `ARM_G2_HI) begin
      g_lo = `ARM_A_CFGA;
      g_hi = `ARM_G2_HI;
    end else if (cur <= `ARM_G3_HI) begin
      g_lo = `ARM_A_OFFC;
      g_hi = `ARM_G3_HI;
    end else begin
      g_lo = `ARM_A_LOCK;
      g_hi = `ARM_A_LOCK;
    end
    ptr_d = cur;
    if (acc_rd_i) begin
      case (rd_loop)
        `ARM_LOOP_STATIC: ptr_d = cur;
        `ARM_LOOP_GROUP:  ptr_d = arm_wrap(cur, g_lo, g_hi);
        `ARM_LOOP_TYPE: begin
          if (cur == `ARM_A_RESULT) begin
            ptr_d = cur;
          end else begin
            ptr_d = arm_wrap(cur, `ARM_G1_LO, `ARM_A_LAST);
          end
        end
        `ARM_LOOP_MAP:    ptr_d = arm_wrap(cur, `ARM_A_RESULT, `ARM_A_LAST);
        default:          ptr_d = cur;
      endcase
    end else if (acc_wr_i & wr_loop) begin
      ptr_d = arm_wrap(cur, `ARM_G1_LO, `ARM_A_LAST);
    end
  end

  // ==========================================
  // Read mux, one whole register per read except a 16-bit result, which gives bits 23:8 only
  reg [`ARM_DW-1:0] rmux;
  reg [`ARM_OW-1:0] rfmt;
  reg [2:0]         rbytes;
  wire [`ARM_DW-1:0] res_src;
  // First result read of a frame takes the live word
  assign res_src = latched_q ? read_latch_q : conversion_result_q;
  always @* begin
    case (cur)
      `ARM_A_RESULT:  rmux = res_src;
      `ARM_A_MOD:     rmux = {20'h00000, modulator_output_q};
      `ARM_A_GAIN:    rmux = pga_gain_config_q;
      `ARM_A_STATCOM: rmux = status_and_comm_q;
      `ARM_A_CFGA:    rmux = configuration_a_q;
      `ARM_A_CFGB:    rmux = configuration_b_q;
      `ARM_A_OFFC:    rmux = offset_correction_q;
      `ARM_A_GAINC:   rmux = gain_correction_q;
      `ARM_A_LOCK:    rmux = {lock_key_q, map_crc_i};
      default:        rmux = `ARM_ZERO;
    endcase
    rfmt   = {rmux, 8'h00};
    rbytes = `ARM_BYTES_3;
    if (cur == `ARM_A_RESULT) begin
      // MSB-aligned except 32S, which is sign-extended into bits 31:24; a serialiser shifts bit 31 first
      case (wfmt)
        `ARM_FMT_16: begin
          rfmt   = {rmux[23:8], 16'h0000};
          rbytes = `ARM_BYTES_2;
        end
        `ARM_FMT_24: begin
          rfmt   = {rmux, 8'h00};
          rbytes = `ARM_BYTES_3;
        end
        `ARM_FMT_32Z: begin
          rfmt   = {rmux, 8'h00};
          rbytes = `ARM_BYTES_4;
        end
        `ARM_FMT_32S: begin
          rfmt   = {{8{rmux[23]}}, rmux};
          rbytes = `ARM_BYTES_4;
        end
        default: begin
          rfmt   = {rmux, 8'h00};
          rbytes = `ARM_BYTES_3;
        end
      endcase
    end
  end

  // ==========================================
  // Sequential state
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conversion_result_q  <= `ARM_ZERO;
      read_latch_q         <= `ARM_ZERO;
      modulator_output_q   <= `ARM_MOD_RST;
      pga_gain_config_q    <= `ARM_ZERO;
      status_and_comm_q    <= `ARM_STAT_RST;
      configuration_a_q    <= `ARM_ZERO;
      configuration_b_q    <= `ARM_ZERO;
      offset_correction_q  <= `ARM_ZERO;
      gain_correction_q    <= `ARM_ZERO;
      lock_key_q           <= 8'h00;
      ptr_q                <= `ARM_A_RESULT;
      active_q             <= 1'b0;
      latched_q            <= 1'b0;
      rd_data_o            <= {`ARM_OW{1'b0}};
      rd_bytes_o           <= `ARM_BYTES_3;
      rd_valid_o           <= 1'b0;
      ptr_o                <= `ARM_A_RESULT;
      offset_corr_enable_o <= 1'b0;
      gain_corr_enable_o   <= 1'b0;
    end else if (ce_i) begin
      rd_valid_o <= 1'b0;
      // Newest sample always lands, even mid-read; the read uses the latch
      if (dr_take) begin
        conversion_result_q <= cal_val;
      end
      if (modulator_clock_i) begin
        modulator_output_q <= comparator_bit_i;
      end
      if (acc_start_i) begin
        active_q  <= 1'b1;
        latched_q <= 1'b0;
      end
      if (acc_rd_i & (acc_start_i | active_q)) begin
        rd_data_o  <= rfmt;
        rd_bytes_o <= rbytes;
        rd_valid_o <= 1'b1;
        ptr_q      <= ptr_d;
        ptr_o      <= ptr_d;
        if (cur == `ARM_A_RESULT) begin
          // Freeze this word; a looped re-read gets the next latch
          read_latch_q <= dr_take ? cal_val : conversion_result_q;
          latched_q    <= ~dr_take;
        end
      end
      if (acc_wr_i & (acc_start_i | active_q)) begin
        ptr_q <= ptr_d;
        ptr_o <= ptr_d;
        case (cur)
          `ARM_A_MOD:     modulator_output_q <= acc_wdata_i[`ARM_COMP_W-1:0];
          `ARM_A_GAIN:    pga_gain_config_q  <= acc_wdata_i;
          `ARM_A_STATCOM: status_and_comm_q  <= acc_wdata_i;
          `ARM_A_CFGA:    configuration_a_q  <= acc_wdata_i;
          `ARM_A_CFGB: begin
            configuration_b_q    <= acc_wdata_i;
            offset_corr_enable_o <= acc_wdata_i[`ARM_OFFEN_B];
            gain_corr_enable_o   <= acc_wdata_i[`ARM_GAINEN_B];
          end
          `ARM_A_OFFC:    offset_correction_q <= acc_wdata_i;
          `ARM_A_GAINC:   gain_correction_q   <= acc_wdata_i;
          `ARM_A_LOCK:    lock_key_q <= acc_wdata_i[`ARM_PW_HI:`ARM_PW_LO];
          default:        ptr_q <= ptr_d;
        endcase
      end
      if (acc_end_i) begin
        active_q  <= 1'b0;
        latched_q <= 1'b0;
      end
      // While a word is frozen, newer data on a cycle without a read clear latched_q
      // so the next read takes result_q, which already holds the newest value
      if (latched_q & dr_take & ~acc_rd_i) begin
        latched_q <= 1'b0;
      end
    end
  end
endmodule // arm_core

// *** verification/arm_core_props.sv ***
`timescale 1ns/10ps
`include "arm_defs.vh"
// ==========================================
// Register bank checker
module arm_core_props (
  input logic        mclk_i,
  input logic        rst_n_i,
  input logic        ce_i,
  input logic [4:0]  acc_addr_i,
  input logic        acc_start_i,
  input logic        acc_end_i,
  input logic        acc_rd_i,
  input logic        acc_wr_i,
  input logic [23:0] acc_wdata_i,
  input logic [31:0] rd_data_o,
  input logic [2:0]  rd_bytes_o,
  input logic        rd_valid_o,
  input logic [4:0]  ptr_o,
  input logic [15:0] map_crc_i,
  input logic        offset_corr_enable_o,
  input logic        gain_corr_enable_o
);
  logic        act_q;
  logic [4:0]  ra_q;
  logic [23:0] st_q;
  logic [1:0]  cb_q;
  wire         act    = acc_start_i | act_q;
  wire [4:0]   cur    = acc_start_i ? acc_addr_i : ptr_o;
  wire         rd_req = ce_i & acc_rd_i & act;
  wire         wr_req = ce_i & acc_wr_i & act;
  wire         unused = (ra_q > 5'h00 && ra_q < 5'h08) || ra_q == 5'h0A ||
                        (ra_q > 5'h10 && ra_q < 5'h1F);
  wire [2:0]   fmt_b  = (st_q[19:18] == 2'h0) ? 3'h2 : (st_q[19:18] == 2'h1) ? 3'h3 : 3'h4;
  // Shadow of the address each answer belongs to
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      act_q <= 1'b0;
      ra_q  <= 5'h00;
      st_q  <= 24'h000000;
      cb_q  <= 2'h0;
    end else if (ce_i) begin
      act_q <= act & ~acc_end_i;
      if (rd_req) ra_q <= cur;
      if (wr_req && cur == `ARM_A_STATCOM) st_q <= acc_wdata_i;
      if (wr_req && cur == `ARM_A_CFGB) cb_q <= acc_wdata_i[1:0];
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_rd;
    rd_req;
  endsequence
  sequence s_cfg;
    wr_req && cur == `ARM_A_CFGB;
  endsequence
  a_rd_answer: assert property (s_rd |=> rd_valid_o)
    else $error("read not answered");
  a_no_stray: assert property (!rd_req |=> !rd_valid_o)
    else $error("answer without read");
  a_other_width: assert property (rd_valid_o && ra_q != 5'h00 |->
    rd_bytes_o == 3'h3 && rd_data_o[7:0] == 8'h00) else $error("bad register width");
  a_fmt_width: assert property (rd_valid_o && ra_q == 5'h00 |-> rd_bytes_o == fmt_b)
    else $error("result width wrong");
  a_mod_pad: assert property (rd_valid_o && ra_q == `ARM_A_MOD |->
    rd_data_o[31:12] == 20'h00000) else $error("modulator upper bits set");
  a_unused_zero: assert property (rd_valid_o && unused |-> rd_data_o == 32'h00000000)
    else $error("unused address not zero");
  a_crc_read: assert property (rd_valid_o && ra_q == `ARM_A_LOCK |->
    rd_data_o[23:8] == $past(map_crc_i)) else $error("checksum field wrong");
  a_static_ptr: assert property (s_rd ##0 st_q[23:22] == 2'h0 |=> ptr_o == $past(cur))
    else $error("static pointer moved");
  a_map_ptr: assert property (s_rd ##0 st_q[23:22] == 2'h3 |=> ptr_o == $past(cur) + 5'h01)
    else $error("map loop step wrong");
  a_corr_flags: assert property (s_cfg |=> ##1 offset_corr_enable_o == cb_q[1] &&
    gain_corr_enable_o == cb_q[0]) else $error("correction enables wrong");
endmodule // arm_core_props

bind arm_core arm_core_props i_props (.mclk_i, .rst_n_i, .ce_i, .acc_addr_i, .acc_start_i,
  .acc_end_i, .acc_rd_i, .acc_wr_i, .acc_wdata_i, .rd_data_o, .rd_bytes_o, .rd_valid_o,
  .ptr_o, .map_crc_i, .offset_corr_enable_o, .gain_corr_enable_o);

// *** verification/arm_host.sv ***
`timescale 1ns/10ps
`include "arm_defs.vh"
// ==========================================
// Serial host model
module arm_host (
  input  logic        mclk_i,
  input  logic [31:0] rd_data_i,
  input  logic [2:0]  rd_bytes_i,
  output logic [4:0]  acc_addr_o,
  output logic        acc_start_o,
  output logic        acc_end_o,
  output logic        acc_rd_o,
  output logic        acc_wr_o,
  output logic [23:0] acc_wdata_o
);
  initial {acc_addr_o, acc_start_o, acc_end_o, acc_rd_o, acc_wr_o, acc_wdata_o} = '0;
  // One cycle of the link; idle data is inverted each cycle so it never matches the word of the cycle before
  task op(input logic [4:0] a, input logic s, r, w, e, input logic [23:0] d);
    @(posedge mclk_i);
    acc_addr_o  <= a;
    acc_start_o <= s;
    acc_rd_o    <= r;
    acc_wr_o    <= w;
    acc_end_o   <= e;
    acc_wdata_o <= w ? d : ~acc_wdata_o;
  endtask
  task wr(input logic [4:0] a, input logic [23:0] d);
    if (a != `ARM_A_MOD) begin
      op(a, 1'b1, 1'b0, 1'b1, 1'b0, d);
      op(a, 1'b0, 1'b0, 1'b0, 1'b1, d);
      op(a, 1'b0, 1'b0, 1'b0, 1'b0, d);
    end
  endtask
  task rd(input logic [4:0] a, output logic [31:0] v, output logic [2:0] b);
    op(a, 1'b1, 1'b1, 1'b0, 1'b0, 24'h000000);
    op(a, 1'b0, 1'b0, 1'b0, 1'b1, 24'h000000);
    #1;
    v = rd_data_i;
    b = rd_bytes_i;
    op(a, 1'b0, 1'b0, 1'b0, 1'b0, 24'h000000);
  endtask
endmodule // arm_host

// *** verification/tb.sv ***
`timescale 1ns/10ps
`include "arm_defs.vh"
module tb;
  logic        mclk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [23:0] adc_data_i = 24'h000000;
  logic        adc_valid_i = 1'b0;
  logic        data_ready_clock_i = 1'b0;
  logic        modulator_clock_i = 1'b0;
  logic [3:0]  comparator_bit_i = 4'h0;
  logic [15:0] map_crc_i = 16'h5A3C;
  logic        ce_i = 1'b1;
  logic [4:0]  acc_addr_i, ptr_o;
  logic        acc_start_i, acc_end_i, acc_rd_i, acc_wr_i, rd_valid_o, adc_ready_o;
  logic [23:0] acc_wdata_i;
  logic [31:0] rd_data_o, v;
  logic [2:0]  rd_bytes_o, b;
  logic        offset_corr_enable_o, gain_corr_enable_o;
  int          error_cnt = 0;
  int          cmp_count = 0;
  always #5 mclk_i = ~mclk_i;
  arm_core i_dut (.mclk_i, .rst_n_i, .ce_i, .acc_addr_i, .acc_start_i, .acc_end_i,
    .acc_rd_i, .acc_wr_i, .acc_wdata_i, .rd_data_o, .rd_bytes_o, .rd_valid_o, .ptr_o,
    .adc_data_i, .adc_valid_i, .adc_ready_o, .data_ready_clock_i, .modulator_clock_i,
    .comparator_bit_i, .map_crc_i, .offset_corr_enable_o, .gain_corr_enable_o);
  arm_host i_host (.mclk_i, .rd_data_i(rd_data_o), .rd_bytes_i(rd_bytes_o),
    .acc_addr_o(acc_addr_i), .acc_start_o(acc_start_i), .acc_end_o(acc_end_i),
    .acc_rd_o(acc_rd_i), .acc_wr_o(acc_wr_i), .acc_wdata_o(acc_wdata_i));
  // ==========================================
  // Checking and closing
  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, s, e);
    end
  endtask
  task conclude();
    $display("comparisons=%0d mismatches=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task pulse_dr();
    @(posedge mclk_i);
    data_ready_clock_i <= 1'b1;
    @(posedge mclk_i);
    data_ready_clock_i <= 1'b0;
  endtask
  // ==========================================
  // Scenarios
  task t_reset();
    i_host.rd(`ARM_A_MOD, v, b);
    chk(v, 32'h00000300);
    i_host.rd(`ARM_A_STATCOM, v, b);
    chk(v, 32'h00000000);
  endtask
  task t_regs();
    logic [14:0] al;
    logic [19:0] ul;
    logic [4:0]  a;
    logic [23:0] d;
    al = {5'h0F, 5'h10, 5'h1F};
    ul = {5'h00, 5'h05, 5'h0A, 5'h1E};
    for (int i = 0; i < 3; i++) begin
      a = al[5*i +: 5];
      d = 24'hC35A96 ^ i;
      i_host.wr(a, d);
      i_host.rd(a, v, b);
      chk(v, (a == `ARM_A_LOCK) ? {d[23:16], map_crc_i, 8'h00} : {d, 8'h00});
    end
    // Read-only and unused places swallow writes
    for (int i = 0; i < 4; i++) begin
      i_host.wr(ul[5*i +: 5], 24'hFFFFFF);
      i_host.rd(ul[5*i +: 5], v, b);
      chk(v, 32'h00000000);
    end
    i_host.wr(`ARM_A_GAINC, 24'h000000);
  endtask
  task t_mod();
    logic [3:0] c;
    for (int i = 0; i < 2; i++) begin
      c = i[0] ? 4'h5 : 4'hA;
      @(posedge mclk_i);
      comparator_bit_i  <= c;
      modulator_clock_i <= 1'b1;
      @(posedge mclk_i);
      modulator_clock_i <= 1'b0;
      i_host.rd(`ARM_A_MOD, v, b);
      chk(v, {20'h00000, c, 8'h00});
    end
  endtask
  task t_loop();
    logic [39:0] tl;
    tl = {5'h0F, 5'h0F, 5'h0F, 5'h10, 5'h1F, 5'h08, 5'h1F, 5'h00};
    for (int i = 0; i < 4; i++) begin
      i_host.wr(`ARM_A_STATCOM, {i[1:0], 4'h1, 18'h00000});
      i_host.rd(tl[39-10*i -: 5], v, b);
      chk({27'h0, ptr_o}, {27'h0, tl[34-10*i -: 5]});
    end
    i_host.wr(`ARM_A_STATCOM, 24'h040000);
  endtask
  task t_fifo();
    int n;
    n = 0;
    @(posedge mclk_i);
    adc_valid_i <= 1'b1;
    adc_data_i  <= 24'h812340;
    repeat (12) begin
      @(posedge mclk_i);
      if (adc_ready_o === 1'b1) begin
        n++;
        adc_data_i <= 24'h812340 + n;
      end
    end
    adc_valid_i <= 1'b0;
    #1;
    chk(n, 8);
    chk({31'h0, adc_ready_o}, 32'h0);
    repeat (8) pulse_dr();
    i_host.rd(`ARM_A_RESULT, v, b);
    chk(v, 32'h81234700);
    chk({31'h0, adc_ready_o}, 32'h1);
    // Empty buffer: a data-ready must not disturb the word
    pulse_dr();
    i_host.rd(`ARM_A_RESULT, v, b);
    chk(v, 32'h81234700);
  endtask
  task t_fmt();
    logic [31:0] e [4];
    logic [2:0]  n [4];
    e = '{32'h81230000, 32'h81234700, 32'h81234700, 32'hFF812347};
    n = '{3'h2, 3'h3, 3'h4, 3'h4};
    for (int i = 0; i < 4; i++) begin
      i_host.wr(`ARM_A_STATCOM, {4'h0, i[1:0], 18'h00000});
      i_host.rd(`ARM_A_RESULT, v, b);
      chk(v & (32'hFFFFFFFF << (8 * (4 - n[i]))), e[i]);
      chk({29'h0, b}, {29'h0, n[i]});
    end
    i_host.wr(`ARM_A_STATCOM, 24'h040000);
  endtask
  task t_corr();
    i_host.wr(`ARM_A_OFFC, 24'h000005);
    i_host.wr(`ARM_A_CFGB, 24'h000003);
    chk({30'h0, offset_corr_enable_o, gain_corr_enable_o}, 32'h3);
    @(posedge mclk_i);
    adc_valid_i <= 1'b1;
    adc_data_i  <= 24'h000010;
    @(posedge mclk_i);
    adc_valid_i <= 1'b0;
    pulse_dr();
    i_host.rd(`ARM_A_RESULT, v, b);
    chk(v, 32'h00000B00);
  endtask
  task t_latch();
    @(posedge mclk_i);
    adc_valid_i <= 1'b1;
    adc_data_i  <= 24'h000020;
    @(posedge mclk_i);
    adc_valid_i <= 1'b0;
    i_host.op(`ARM_A_RESULT, 1'b1, 1'b1, 1'b0, 1'b0, 24'h000000);
    i_host.op(`ARM_A_RESULT, 1'b0, 1'b0, 1'b0, 1'b0, 24'h000000);
    // Re-read with a data-ready on the same edge: old word now, new one next
    i_host.op(`ARM_A_RESULT, 1'b0, 1'b1, 1'b0, 1'b0, 24'h000000);
    data_ready_clock_i <= 1'b1;
    chk(rd_data_o, 32'h00000B00);
    i_host.op(`ARM_A_RESULT, 1'b0, 1'b0, 1'b0, 1'b0, 24'h000000);
    data_ready_clock_i <= 1'b0;
    i_host.op(`ARM_A_RESULT, 1'b0, 1'b1, 1'b0, 1'b0, 24'h000000);
    chk(rd_data_o, 32'h00000B00);
    i_host.op(`ARM_A_RESULT, 1'b0, 1'b0, 1'b0, 1'b1, 24'h000000);
    i_host.op(`ARM_A_RESULT, 1'b0, 1'b0, 1'b0, 1'b0, 24'h000000);
    chk(rd_data_o, 32'h00001B00);
  endtask
  task t_wloop();
    i_host.wr(`ARM_A_STATCOM, 24'h240000);
    i_host.op(`ARM_A_OFFC, 1'b1, 1'b0, 1'b1, 1'b0, 24'h000005);
    i_host.op(`ARM_A_GAINC, 1'b0, 1'b0, 1'b1, 1'b0, 24'h00A5C3);
    i_host.op(`ARM_A_GAINC, 1'b0, 1'b0, 1'b0, 1'b1, 24'h000000);
    i_host.op(`ARM_A_GAINC, 1'b0, 1'b0, 1'b0, 1'b0, 24'h000000);
    chk({27'h0, ptr_o}, 32'h00000011);
    i_host.rd(`ARM_A_GAINC, v, b);
    chk(v, 32'h00A5C300);
    i_host.wr(`ARM_A_STATCOM, 24'h040000);
  endtask
  task t_ce();
    @(posedge mclk_i);
    ce_i              <= 1'b0;
    comparator_bit_i  <= 4'hF;
    modulator_clock_i <= 1'b1;
    @(posedge mclk_i);
    ce_i              <= 1'b1;
    modulator_clock_i <= 1'b0;
    i_host.rd(`ARM_A_MOD, v, b);
    chk(v, 32'h00000500);
  endtask
  initial begin
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_regs();
    t_mod();
    t_loop();
    t_fifo();
    t_fmt();
    t_corr();
    t_latch();
    t_wloop();
    t_ce();
    conclude();
  end
  initial begin
    #100000;
    error_cnt++;
    conclude();
  end
endmodule // tb
